// >>> rtl/dsl_port_pkg.sv
package dsl_port_pkg;

  // clock and derived rates
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned FLASH_HZ = 2;
  localparam int unsigned FLASH_HALF = CLK_HZ / (FLASH_HZ * 2);
  localparam int unsigned SUP_BAUD = 9600;
  localparam int unsigned SUP_BAUD_DIV = CLK_HZ / SUP_BAUD;
  localparam int unsigned SUP_DATA_BITS = 8;
  localparam int unsigned SUP_STOP_BITS = 1;
  localparam bit SUP_PARITY_EN = 1'b0;
  localparam int unsigned INT_BIT_HZ = 64_000;
  localparam int unsigned INT_HALF = CLK_HZ / (INT_BIT_HZ * 2);
  localparam int unsigned INT_W = 10;

  // register offsets (byte addresses)
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_IDLE = 4'h4;
  localparam logic [3:0] ADDR_CMD = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hc;

  // command bits at ADDR_CMD
  localparam int unsigned CMD_IDLE_COMMIT = 0;
  localparam int unsigned CMD_BACKUP = 1;
  localparam int unsigned CMD_RECALL = 2;
  localparam int unsigned CMD_DEFAULT = 3;

  // sticky flag bits, low nibble of ADDR_STAT
  localparam int unsigned FLG_SAVED = 0;
  localparam int unsigned FLG_RESTORED = 1;
  localparam int unsigned FLG_DEFAULTED = 2;
  localparam int unsigned FLG_REJECTED = 3;
  localparam int unsigned STAT_PINS_POS = 8;

  // role and clock source codes
  localparam logic [1:0] ROLE_CENTRAL = 2'h1;
  localparam logic [1:0] ROLE_REMOTE = 2'h2;
  localparam logic [1:0] PCLK_INT = 2'h0;
  localparam logic [1:0] PCLK_DTE = 2'h1;
  localparam logic [1:0] PCLK_DSL = 2'h2;

  // working configuration, low bits of ADDR_CFG in this order (msb first)
  typedef struct packed {
    logic [1:0] role;
    logic [7:0] idle_code;
    logic [4:0] rate_n;
    logic rate56;
    logic clk_inv;
    logic data_inv;
    logic ctl_perm;
    logic terminal_timing_select;
    logic [1:0] pclk_src;
  } cfg_t;

  localparam int unsigned CFG_W = $bits(cfg_t);

  localparam cfg_t CFG_FACTORY = '{
    role: ROLE_CENTRAL,
    idle_code: 8'hff,
    rate_n: 5'h01,
    rate56: 1'b0,
    clk_inv: 1'b0,
    data_inv: 1'b0,
    ctl_perm: 1'b0,
    terminal_timing_select: 1'b1,
    pclk_src: PCLK_INT
  };

  // pins from outside the clock domain
  typedef struct packed {
    logic dte_txc;
    logic dte_txd;
    logic dte_ext_clk;
    logic dte_rts;
    logic dte_dtr;
    logic loop_clk;
    logic loop_sync;
    logic loop_handshake;
    logic user_present;
    logic local_test;
    logic peer_test;
    logic alarm_any;
  } pin_t;

  typedef struct packed {
    logic loop;
    logic link;
    logic test;
    logic customer_premises_role;
    logic alarm;
  } led_t;

  typedef struct packed {
    logic cts;
    logic dsr;
    logic dcd;
  } ctl_t;

endpackage

// >>> rtl/dsl_port_ctrl.sv
`timescale 1ns/10ps
// Function
// - loop lamp on when synced, flashing after handshake, off otherwise
// - link lamp follows presence of the user interface
// - test lamp on for local test, flashing for peer test, else off
// - role lamp lit for remote unit, dark for central unit
// - alarm lamp on while any alarm is active
// - role code one selects central unit, two selects remote unit
// - idle code sent on idle channels; new code applies only on commit
// - line rate set only on central unit; remote follows peer rate
// - dte rate is N times 64k or N times 56k
// - normal clock samples dte data rising, inverted samples falling
// - inverted data polarity complements bits both directions
// - permanent mode asserts all control outputs; normal follows inputs
// - terminal timing on uses own clock, off uses dte clock
// - primary clock is internal, dte port, or loop recovered
// - dte primary clock only with terminal timing off; reject conflict
// - backup copies working config to stored slot, reports saved
// - recall loads stored config, keeps current role
// - default loads factory config (idle ff, 1x64k), keeps role
// - supervisory port runs 9600 baud, 8 data, no parity, 1 stop
module dsl_port_ctrl
  import dsl_port_pkg::*;
#(
  parameter int unsigned FLASH_HALF_CYC = FLASH_HALF,
  parameter int unsigned SUP_DIV_CYC = SUP_BAUD_DIV
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // asynchronous pins
  input wire pin_t i_pins,
  // line side, same clock domain as the transceiver interface
  input wire logic i_line_rxd,
  input wire logic i_line_rx_strobe,
  input wire logic [4:0] i_peer_rate,
  input wire logic i_peer_rate_valid,
  output logic o_line_txd,
  output logic o_line_tx_strobe,
  // dte side
  output logic o_dte_rxd,
  output logic o_dte_rxc,
  output ctl_t o_dce_ctl,
  // supervisory port timing
  output logic o_sup_baud_tick,
  // indicators
  output led_t o_leds,
  output cfg_t o_cfg
);

  localparam int unsigned FLASH_W = $clog2(FLASH_HALF_CYC + 1);
  localparam int unsigned SUP_W = $clog2(SUP_DIV_CYC + 1);

  typedef struct packed {
    cfg_t cfg;
    cfg_t store;
    logic [7:0] idle_stage;
    logic [3:0] flags;
    pin_t s1;
    pin_t s2;
    pin_t s3;
    logic [FLASH_W-1:0] flash_cnt;
    logic flash;
    logic [SUP_W-1:0] sup_cnt;
    logic sup_tick;
    logic [INT_W-1:0] int_cnt;
    logic int_clk;
    logic int_clk_d;
    logic dte_bit;
    logic line_bit;
    logic [2:0] bit_idx;
    logic [4:0] slot;
    logic line_txd;
    logic line_stb;
    logic dte_rxd;
    ctl_t ctl;
    led_t leds;
    logic [31:0] rdata;
  } st_t;

  st_t r;
  st_t nxt;

  // line and dte data rest high, like an idle marking line
  localparam st_t ST_RESET = '{
    cfg: CFG_FACTORY,
    store: CFG_FACTORY,
    idle_stage: CFG_FACTORY.idle_code,
    flags: 4'h0,
    s1: '0,
    s2: '0,
    s3: '0,
    flash_cnt: '0,
    flash: 1'b0,
    sup_cnt: '0,
    sup_tick: 1'b0,
    int_cnt: '0,
    int_clk: 1'b0,
    int_clk_d: 1'b0,
    dte_bit: 1'b0,
    line_bit: 1'b0,
    bit_idx: 3'h0,
    slot: 5'h00,
    line_txd: 1'b1,
    line_stb: 1'b0,
    dte_rxd: 1'b1,
    ctl: '0,
    leds: '0,
    rdata: 32'h0000_0000
  };

  always_comb begin
    cfg_t wcfg;
    cfg_t base;
    logic [3:0] set_f;
    logic [3:0] clr_f;
    logic txc_rise;
    logic txc_fall;
    logic ext_rise;
    logic ext_fall;
    logic loop_rise;
    logic int_rise;
    logic int_fall;
    logic prim_tick;
    logic out_tick;
    logic sample;
    logic slot_active;
    logic stuff_bit;
    logic tx_bit;
    wcfg = '0;
    base = r.cfg;
    set_f = 4'h0;
    clr_f = 4'h0;
    txc_rise = 1'b0;
    txc_fall = 1'b0;
    ext_rise = 1'b0;
    ext_fall = 1'b0;
    loop_rise = 1'b0;
    int_rise = 1'b0;
    int_fall = 1'b0;
    prim_tick = 1'b0;
    out_tick = 1'b0;
    sample = 1'b0;
    slot_active = 1'b0;
    stuff_bit = 1'b0;
    tx_bit = 1'b0;
    nxt = r;

    // two-stage synchroniser, third stage only for edge finding
    nxt.s1 = i_pins;
    nxt.s2 = r.s1;
    nxt.s3 = r.s2;

    // free-running flash divider
    // runs with no lamp flashing, so all lamps flash in phase
    if (r.flash_cnt == FLASH_W'(FLASH_HALF_CYC - 1)) begin
      nxt.flash_cnt = '0;
      nxt.flash = ~r.flash;
    end else begin
      nxt.flash_cnt = r.flash_cnt + FLASH_W'(1);
    end

    // baud enable for the supervisory uart, 8n1 framing is fixed
    nxt.sup_tick = 1'b0;
    if (r.sup_cnt == SUP_W'(SUP_DIV_CYC - 1)) begin
      nxt.sup_cnt = '0;
      nxt.sup_tick = 1'b1;
    end else begin
      nxt.sup_cnt = r.sup_cnt + SUP_W'(1);
    end

    // internal bit clock
    // near 64 kHz only: the half period is cut to whole cycles
    nxt.int_clk_d = r.int_clk;
    if (r.int_cnt == INT_W'(INT_HALF - 1)) begin
      nxt.int_cnt = '0;
      nxt.int_clk = ~r.int_clk;
    end else begin
      nxt.int_cnt = r.int_cnt + INT_W'(1);
    end

    // edges from stages two and three; stage one only feeds stage two
    txc_rise = r.s2.dte_txc & ~r.s3.dte_txc;
    txc_fall = ~r.s2.dte_txc & r.s3.dte_txc;
    ext_rise = r.s2.dte_ext_clk & ~r.s3.dte_ext_clk;
    ext_fall = ~r.s2.dte_ext_clk & r.s3.dte_ext_clk;
    loop_rise = r.s2.loop_clk & ~r.s3.loop_clk;
    int_rise = r.int_clk & ~r.int_clk_d;
    int_fall = ~r.int_clk & r.int_clk_d;

    // dte receive sampling edge chosen by clock polarity
    sample = r.cfg.clk_inv ? txc_fall : txc_rise;
    if (sample) begin
      nxt.dte_bit = r.s2.dte_txd ^ r.cfg.data_inv;
    end

    // primary clock source drives the line framer
    unique case (r.cfg.pclk_src)
      PCLK_DTE: prim_tick = ext_rise;
      PCLK_DSL: prim_tick = loop_rise;
      default: prim_tick = int_rise;
    endcase

    // slots at or above N carry idle code
    slot_active = (r.slot < r.cfg.rate_n);
    stuff_bit = r.cfg.rate56 && (r.bit_idx == 3'h7);
    if (!slot_active) begin
      tx_bit = r.cfg.idle_code[3'h7 - r.bit_idx];
    end else if (stuff_bit) begin
      tx_bit = 1'b1;
    end else begin
      tx_bit = r.dte_bit;
    end

    // bit and strobe leave together; the strobe lasts one cycle
    nxt.line_stb = 1'b0;
    if (prim_tick) begin
      nxt.line_txd = tx_bit;
      nxt.line_stb = 1'b1;
      nxt.bit_idx = r.bit_idx + 3'h1;
      if (r.bit_idx == 3'h7) begin
        nxt.slot = r.slot + 5'h01;
      end
    end

    // data toward the dte
    if (i_line_rx_strobe) begin
      nxt.line_bit = i_line_rxd;
    end
    if (r.cfg.terminal_timing_select) begin
      out_tick = int_fall;
    end else begin
      out_tick = ext_fall;
    end
    if (out_tick) begin
      nxt.dte_rxd = r.line_bit ^ r.cfg.data_inv;
    end

    // control leads
    // dcd follows loop sync, there is no carrier pin of its own
    if (r.cfg.ctl_perm) begin
      nxt.ctl = '{cts: 1'b1, dsr: 1'b1, dcd: 1'b1};
    end else begin
      nxt.ctl.cts = r.s2.dte_rts;
      nxt.ctl.dsr = r.s2.dte_dtr;
      nxt.ctl.dcd = r.s2.loop_sync;
    end

    // indicators
    if (r.s2.loop_sync) begin
      nxt.leds.loop = 1'b1;
    end else if (r.s2.loop_handshake) begin
      nxt.leds.loop = r.flash;
    end else begin
      nxt.leds.loop = 1'b0;
    end
    nxt.leds.link = r.s2.user_present;
    // a local test outranks the peer's
    if (r.s2.local_test) begin
      nxt.leds.test = 1'b1;
    end else if (r.s2.peer_test) begin
      nxt.leds.test = r.flash;
    end else begin
      nxt.leds.test = 1'b0;
    end
    nxt.leds.customer_premises_role = (r.cfg.role == ROLE_REMOTE);
    nxt.leds.alarm = r.s2.alarm_any;

    // remote unit takes the rate run by the central unit
    if (r.cfg.role == ROLE_REMOTE && i_peer_rate_valid) begin
      nxt.cfg.rate_n = i_peer_rate;
    end

    // register writes
    // decoded on the strobe edge, so the master never waits
    if (i_wr) begin
      unique case (i_addr)
        ADDR_CFG: begin
          wcfg = cfg_t'(i_wdata[CFG_W-1:0]);
          if (wcfg.role != ROLE_CENTRAL && wcfg.role != ROLE_REMOTE) begin
            wcfg.role = r.cfg.role;
          end
          if (r.cfg.role == ROLE_REMOTE) begin
            wcfg.rate_n = nxt.cfg.rate_n;
          end
          // a config write never moves the idle code; commit, recall and default do
          wcfg.idle_code = r.cfg.idle_code;
          // a refused write leaves every field as it was
          if (wcfg.pclk_src == PCLK_DTE && wcfg.terminal_timing_select) begin
            set_f[FLG_REJECTED] = 1'b1;
          end else if (wcfg.pclk_src == 2'h3) begin
            set_f[FLG_REJECTED] = 1'b1;
          end else begin
            nxt.cfg = wcfg;
          end
        end
        ADDR_IDLE: nxt.idle_stage = i_wdata[7:0];
        ADDR_CMD: begin
          if (i_wdata[CMD_IDLE_COMMIT]) begin
            nxt.cfg.idle_code = r.idle_stage;
          end
          // backup stores the config as it stood before this write
          if (i_wdata[CMD_BACKUP]) begin
            nxt.store = r.cfg;
            set_f[FLG_SAVED] = 1'b1;
          end
          // default outranks recall; both keep the role
          if (i_wdata[CMD_DEFAULT]) begin
            base = CFG_FACTORY;
            base.role = r.cfg.role;
            nxt.cfg = base;
            nxt.idle_stage = CFG_FACTORY.idle_code;
            set_f[FLG_DEFAULTED] = 1'b1;
          end else if (i_wdata[CMD_RECALL]) begin
            base = r.store;
            base.role = r.cfg.role;
            nxt.cfg = base;
            nxt.idle_stage = r.store.idle_code;
            set_f[FLG_RESTORED] = 1'b1;
          end
        end
        ADDR_STAT: clr_f = i_wdata[3:0];
        default: ;
      endcase
    end
    // a flag raised in the same cycle as its clear survives
    nxt.flags = (r.flags & ~clr_f) | set_f;

    // read data stands only in the cycle after the strobe
    // unmapped and command reads return zero
    nxt.rdata = 32'h0000_0000;
    if (i_rd) begin
      unique case (i_addr)
        ADDR_CFG: nxt.rdata = 32'(r.cfg);
        ADDR_IDLE: nxt.rdata = 32'(r.idle_stage);
        ADDR_STAT: begin
          nxt.rdata[3:0] = r.flags;
          nxt.rdata[STAT_PINS_POS +: $bits(pin_t)] = r.s2;
        end
        default: nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // reset loads one constant record, so no state escapes it
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r <= ST_RESET;
    end else begin
      r <= nxt;
    end
  end

  // every output is a register bit; nothing combinational leaves
  assign o_rdata = r.rdata;
  assign o_line_txd = r.line_txd;
  assign o_line_tx_strobe = r.line_stb;
  assign o_dte_rxd = r.dte_rxd;
  assign o_dte_rxc = r.int_clk;
  assign o_dce_ctl = r.ctl;
  assign o_sup_baud_tick = r.sup_tick;
  assign o_leds = r.leds;
  assign o_cfg = r.cfg;

endmodule // dsl_port_ctrl

// >>> test/dte_model.sv
`timescale 1ns/10ps
module dte_model (
  output logic o_txc,
  output logic o_txd
);
  initial begin
    o_txc = 1'b0;
    o_txd = 1'b0;
    // odd start offset keeps it out of phase with the unit clock
    #37;
    forever begin
      #100 o_txc = ~o_txc;
      // data follows the clock, so the two sampling edges see opposite bits
      o_txd = o_txc;
    end
  end
endmodule // dte_model

// >>> test/dsl_port_ctrl_assertions.sv
`timescale 1ns/10ps
module dsl_port_ctrl_checker
  import dsl_port_pkg::*;
#(
  parameter int unsigned FLASH_HALF_CYC = FLASH_HALF,
  parameter int unsigned SUP_DIV_CYC = SUP_BAUD_DIV
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire pin_t i_pins,
  input wire logic i_peer_rate_valid,
  input wire logic o_sup_baud_tick,
  input wire ctl_t o_dce_ctl,
  input wire led_t o_leds,
  input wire cfg_t o_cfg
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  wire cfg_wr = i_wr && i_addr == ADDR_CFG;
  // count fixed for a divider of 4; must follow SUP_DIV_CYC by hand
  sequence tick_gap_s;
    (!o_sup_baud_tick)[*3] ##1 o_sup_baud_tick;
  endsequence
  // pins pass two sync stages, five steady cycles covers the lag
  loop_on_a: assert property (
    i_pins.loop_sync[*5] |-> o_leds.loop)
    else $error("loop lamp dark while synced");
  link_on_a: assert property (
    i_pins.user_present[*5] |-> o_leds.link)
    else $error("link lamp dark with user side present");
  test_on_a: assert property (
    i_pins.local_test[*5] |-> o_leds.test)
    else $error("test lamp dark during local test");
  role_lamp_a: assert property (
    (o_cfg.role == ROLE_REMOTE)[*2] |-> o_leds.customer_premises_role)
    else $error("role lamp dark on remote unit");
  alarm_on_a: assert property (
    i_pins.alarm_any[*5] |-> o_leds.alarm)
    else $error("alarm lamp dark with alarm active");
  perm_ctl_a: assert property (
    o_cfg.ctl_perm[*2] |-> o_dce_ctl == 3'h7)
    else $error("control outputs not all on in permanent mode");
  baud_gap_a: assert property (
    o_sup_baud_tick |=> tick_gap_s)
    else $error("baud tick spacing wrong");
  reject_cfg_a: assert property (
    cfg_wr && i_wdata[1:0] == PCLK_DTE && i_wdata[2] && !i_peer_rate_valid
      |=> $stable(o_cfg))
    else $error("conflicting clock setting accepted");
  idle_hold_a: assert property (
    i_wr && i_addr != ADDR_CMD |=> $stable(o_cfg.idle_code))
    else $error("idle code changed without commit");
  remote_rate_a: assert property (
    cfg_wr && o_cfg.role == ROLE_REMOTE && !i_peer_rate_valid
      && i_wdata[21:20] == ROLE_REMOTE |=> $stable(o_cfg.rate_n))
    else $error("remote unit took a local rate");
endmodule // dsl_port_ctrl_checker

bind dsl_port_ctrl dsl_port_ctrl_checker #(
  .FLASH_HALF_CYC(FLASH_HALF_CYC),
  .SUP_DIV_CYC(SUP_DIV_CYC)
) chk_u (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_pins(i_pins),
  .i_peer_rate_valid(i_peer_rate_valid),
  .o_sup_baud_tick(o_sup_baud_tick), .o_dce_ctl(o_dce_ctl),
  .o_leds(o_leds), .o_cfg(o_cfg)
);

// >>> test/dsl_port_ctrl_tb.sv
`timescale 1ns/10ps
module dsl_port_ctrl_tb
  import dsl_port_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic line_rxd = 1'b1;
  logic strobe = 1'b0;
  logic [3:0] sc = 4'h0;
  logic [4:0] peer_rate = 5'h00;
  logic peer_v = 1'b0;
  logic txc;
  logic txd;
  logic dte_rxd;
  logic tx_d;
  logic tx_stb;
  logic rxc;
  logic [31:0] rdata;
  logic [31:0] d;
  ctl_t ctl;
  led_t leds;
  cfg_t cfg;
  cfg_t c;
  cfg_t c2;
  pin_t pin_v = '0;
  pin_t pins;
  logic [1:0] srcs [3] = '{PCLK_INT, PCLK_DTE, PCLK_DSL};
  int error_cnt = 0;
  int total_checks = 0;

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    sc <= sc + 4'h1;
    strobe <= sc == 4'h0;
  end

  always_comb begin
    pins = pin_v;
    pins.dte_txc = txc;
    pins.dte_txd = txd;
    pins.dte_ext_clk = txc;
  end

  dsl_port_ctrl #(.FLASH_HALF_CYC(8), .SUP_DIV_CYC(4)) dut_u (
    .i_ref_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_pins(pins),
    .i_line_rxd(line_rxd), .i_line_rx_strobe(strobe),
    .i_peer_rate(peer_rate), .i_peer_rate_valid(peer_v),
    .o_line_txd(tx_d), .o_line_tx_strobe(tx_stb), .o_dte_rxd(dte_rxd),
    .o_dte_rxc(rxc), .o_dce_ctl(ctl), .o_sup_baud_tick(),
    .o_leds(leds), .o_cfg(cfg)
  );
  dte_model dte_u (.o_txc(txc), .o_txd(txd));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  task automatic see(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic flash(input int b);
    int ones;
    ones = 0;
    repeat (32) begin
      @(negedge clk);
      ones += leds[b];
    end
    chk(ones, 16);
  endtask

  // counts ones over 64 line bits, each taken while its strobe stands
  task automatic line_ones(input int n);
    int ones;
    ones = 0;
    repeat (64) begin
      @(negedge clk);
      while (!tx_stb) @(negedge clk);
      ones += tx_d;
    end
    chk(ones, n);
  endtask

  task automatic rxc_duty;
    int ones;
    ones = 0;
    repeat (2 * INT_HALF) begin
      @(negedge clk);
      ones += rxc;
    end
    chk(ones, INT_HALF);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #500_000;
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    c = CFG_FACTORY;
    rd(ADDR_CFG, d);
    chk(d, {10'h0, c});
    chk(leds, 5'h00);
    c.role = ROLE_REMOTE;
    c2 = c;
    c2.rate_n = 5'h07;
    wr(ADDR_CFG, {10'h0, c});
    wr(ADDR_CFG, {10'h0, c2});
    see(2);
    chk(cfg, c);
    chk(leds.customer_premises_role, 1'b1);
    @(posedge clk);
    peer_rate <= 5'h09;
    peer_v <= 1'b1;
    @(posedge clk);
    peer_v <= 1'b0;
    c.rate_n = 5'h09;
    see(1);
    chk(cfg, c);
    c.role = ROLE_CENTRAL;
    wr(ADDR_CFG, {10'h0, c});
    c.rate_n = 5'h1f;
    c.rate56 = 1'b1;
    wr(ADDR_CFG, {10'h0, c});
    see(2);
    chk(cfg, c);
    chk(leds.customer_premises_role, 1'b0);
    // terminal timing still on, so the dte source must bounce
    c2 = c;
    c2.pclk_src = PCLK_DTE;
    wr(ADDR_CFG, {10'h0, c2});
    c2.pclk_src = 2'h3;
    c2.terminal_timing_select = 1'b0;
    wr(ADDR_CFG, {10'h0, c2});
    rd(ADDR_STAT, d);
    chk(cfg, c);
    chk(d[3:0], 4'h8);
    wr(ADDR_STAT, 32'h0000_000f);
    c.terminal_timing_select = 1'b0;
    foreach (srcs[i]) begin
      c.pclk_src = srcs[i];
      wr(ADDR_CFG, {10'h0, c});
      see(1);
      chk(cfg, c);
    end
    wr(ADDR_IDLE, 32'h0000_005a);
    see(1);
    chk(cfg.idle_code, 8'hff);
    wr(ADDR_CMD, 32'h1 << CMD_IDLE_COMMIT);
    c.idle_code = 8'h5a;
    see(1);
    chk(cfg, c);
    wr(ADDR_CMD, 32'h1 << CMD_BACKUP);
    rd(ADDR_STAT, d);
    chk(d[3:0], 4'h1);
    c2 = c;
    c2.ctl_perm = 1'b1;
    c2.data_inv = 1'b1;
    c2.clk_inv = 1'b1;
    wr(ADDR_CFG, {10'h0, c2});
    see(2);
    chk(ctl, 3'h7);
    c2.role = ROLE_REMOTE;
    wr(ADDR_CFG, {10'h0, c2});
    wr(ADDR_CMD, 32'h1 << CMD_RECALL);
    c.role = ROLE_REMOTE;
    see(1);
    chk(cfg, c);
    wr(ADDR_CMD, 32'h1 << CMD_DEFAULT);
    c = CFG_FACTORY;
    c.role = ROLE_REMOTE;
    rd(ADDR_STAT, d);
    chk(cfg, c);
    chk(d[3:0], 4'h7);
    c.role = ROLE_CENTRAL;
    wr(ADDR_CFG, {10'h0, c});
    @(posedge clk);
    pin_v.dte_rts <= 1'b1;
    pin_v.loop_sync <= 1'b1;
    pin_v.user_present <= 1'b1;
    pin_v.alarm_any <= 1'b1;
    pin_v.local_test <= 1'b1;
    pin_v.peer_test <= 1'b1;
    see(6);
    chk(ctl, 3'h5);
    chk(leds, 5'h1d);
    @(posedge clk);
    pin_v.loop_sync <= 1'b0;
    pin_v.loop_handshake <= 1'b1;
    pin_v.local_test <= 1'b0;
    see(6);
    flash(4);
    flash(2);
    @(posedge clk);
    pin_v <= '0;
    see(6);
    chk(leds, 5'h00);
    // one own-clock period holds exactly one falling edge
    c.data_inv = 1'b1;
    wr(ADDR_CFG, {10'h0, c});
    rxc_duty();
    see(8);
    chk(dte_rxd, 1'b0);
    c.data_inv = 1'b0;
    wr(ADDR_CFG, {10'h0, c});
    rxc_duty();
    see(8);
    chk(dte_rxd, 1'b1);
    // line timed by the dte clock; dte data equals that clock
    c.terminal_timing_select = 1'b0;
    c.pclk_src = PCLK_DTE;
    c.rate_n = 5'h1f;
    wr(ADDR_CFG, {10'h0, c});
    see(16);
    chk(cfg, c);
    line_ones(64);
    wr(ADDR_IDLE, 32'h0000_0000);
    wr(ADDR_CMD, 32'h1 << CMD_IDLE_COMMIT);
    c.idle_code = 8'h00;
    c.clk_inv = 1'b1;
    wr(ADDR_CFG, {10'h0, c});
    see(16);
    line_ones(0);
    wr(ADDR_IDLE, 32'h0000_0001);
    wr(ADDR_CMD, 32'h1 << CMD_IDLE_COMMIT);
    c.rate56 = 1'b1;
    wr(ADDR_CFG, {10'h0, c});
    see(16);
    line_ones(8);
    wr(ADDR_IDLE, 32'h0000_0003);
    wr(ADDR_CMD, 32'h1 << CMD_IDLE_COMMIT);
    c.clk_inv = 1'b0;
    c.rate_n = 5'h00;
    wr(ADDR_CFG, {10'h0, c});
    see(16);
    line_ones(16);
    c.data_inv = 1'b1;
    wr(ADDR_CFG, {10'h0, c});
    see(16);
    chk(dte_rxd, 1'b0);
    final_report();
  end
endmodule // dsl_port_ctrl_tb
